// [lar_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none

module lar_ctrl
  import lar_pkg::*;
#(
  parameter int ADDR_W = 10
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // user command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_rmw,
  input wire logic cmd_burst,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic cmd_wdata,
  // user response
  output logic rsp_valid,
  output logic rsp_rdata,
  // memory pins
  output logic ram_ce_n,
  output logic ram_we_n,
  output logic [ADDR_W-1:0] ram_addr,
  output logic ram_d,
  output logic ram_d_oe_n,
  input wire logic ram_q
);

  lar_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] wcnt_r, wcnt_nxt;
  logic wr_r, wr_nxt;
  logic rd_r, rd_nxt;
  logic burst_r, burst_nxt;
  logic rd_done_r, rd_done_nxt;
  logic ce_n_r, ce_n_nxt;
  logic we_n_r, we_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic d_r, d_nxt;
  logic rdata_r, rdata_nxt;
  logic rsp_r, rsp_nxt;
  logic q_level;

  lar_sync u_qsync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_i(ram_q),
    .level_o(q_level)
  );

  assign cmd_ready = (state_r == ST_IDLE);
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdata_r;
  assign ram_ce_n = ce_n_r;
  assign ram_we_n = we_n_r;
  assign ram_addr = addr_r;
  assign ram_d = d_r;
  assign ram_d_oe_n = oe_n_r;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;
    wcnt_nxt = wcnt_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    burst_nxt = burst_r;
    rd_done_nxt = rd_done_r;
    ce_n_nxt = ce_n_r;
    we_n_nxt = we_n_r;
    oe_n_nxt = oe_n_r;
    addr_nxt = addr_r;
    d_nxt = d_r;
    rdata_nxt = rdata_r;
    rsp_nxt = 1'b0;
    // strobe low time, saturating; kept across a burst
    if (!we_n_r && wcnt_r != 8'hFF)
    begin
      wcnt_nxt = wcnt_r + 8'h01;
    end
    // bus is driven only once the device output is surely off
    if (!we_n_r && wcnt_r >= TWLQZ_CY - 8'h01)
    begin
      oe_n_nxt = 1'b0;
    end
    unique case (state_r)
      ST_IDLE:
      begin
        if (cmd_valid)
        begin
          addr_nxt = cmd_addr;
          d_nxt = cmd_wdata;
          wr_nxt = cmd_write | cmd_rmw;
          rd_nxt = !cmd_write | cmd_rmw;
          burst_nxt = cmd_burst & cmd_write & !cmd_rmw;
          rd_done_nxt = 1'b0;
          // a read must see the strobe high before the enable falls
          if (!cmd_write || cmd_rmw)
          begin
            we_n_nxt = 1'b1;
            oe_n_nxt = 1'b1;
            wcnt_nxt = 8'h00;
          end
          state_nxt = ST_ASU;
        end
      end
      ST_ASU:
      begin
        // address has stood one cycle; enable fall latches it
        ce_n_nxt = 1'b0;
        cnt_nxt = 8'h00;
        state_nxt = ST_ACT;
      end
      ST_ACT:
      begin
        if (rd_r && !rd_done_r && cnt_r >= READ_CY - 8'h01)
        begin
          rdata_nxt = q_level;
          rd_done_nxt = 1'b1;
        end
        // write portion opens after any read part is done
        if (wr_r && we_n_r && (!rd_r || rd_done_r))
        begin
          we_n_nxt = 1'b0;
          wcnt_nxt = 8'h00;
        end
        if (cnt_r >= TELEH_CY - 8'h01 && (!rd_r || rd_done_r) &&
            (!wr_r || (!we_n_r && wcnt_r >= WEND_CY - 8'h01)))
        begin
          // enable rise terminates the write; data still held
          ce_n_nxt = 1'b1;
          rsp_nxt = 1'b1;
          cnt_nxt = 8'h00;
          state_nxt = ST_REC;
        end
      end
      ST_REC:
      begin
        // strobe stays low through a burst, else rises now
        if (!burst_r)
        begin
          we_n_nxt = 1'b1;
        end
        if (we_n_r)
        begin
          oe_n_nxt = 1'b1;
        end
        if (cnt_r >= TEHEL_CY - 8'h01)
        begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // no refresh: the controller idles with the enable high
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      wcnt_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      burst_r <= 1'b0;
      rd_done_r <= 1'b0;
      ce_n_r <= PIN_IDLE;
      we_n_r <= PIN_IDLE;
      oe_n_r <= PIN_IDLE;
      addr_r <= '0;
      d_r <= 1'b0;
      rdata_r <= 1'b0;
      rsp_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      wcnt_r <= wcnt_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      burst_r <= burst_nxt;
      rd_done_r <= rd_done_nxt;
      ce_n_r <= ce_n_nxt;
      we_n_r <= we_n_nxt;
      oe_n_r <= oe_n_nxt;
      addr_r <= addr_nxt;
      d_r <= d_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
    end
  end

endmodule // lar_ctrl

`default_nettype wire

// [lar_pkg.sv]
`default_nettype none
package lar_pkg;

  // clock period in picoseconds (200 MHz)
  localparam int CLK_PS = 5000;

  // device timing, slower speed grade, in ns
  localparam int TELEH_NS = 250;  // enable low width, least
  localparam int TEHEL_NS = 100;  // enable high width, least
  localparam int TELQV_NS = 250;  // enable-to-data access, most
  localparam int TWLQZ_NS = 160;  // write-low to output off, most
  localparam int TDVWH_NS = 110;  // data setup to end of write, least
  localparam int TWLWH_NS = 130;  // write pulse width, least

  // synchroniser depth on the returned data pin
  localparam int SYNC_STAGES = 3;

  // cycle counts: least times round up
  localparam logic [7:0] TELEH_CY = 8'((TELEH_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] TEHEL_CY = 8'((TEHEL_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] TWLQZ_CY = 8'((TWLQZ_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] TDVWH_CY = 8'((TDVWH_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] TWLWH_CY = 8'((TWLWH_NS * 1000 + CLK_PS - 1) / CLK_PS);
  // sample point: access time, one cycle for a pin change landing on
  // an edge, then the synchroniser and its holding register
  localparam logic [7:0] READ_CY =
    8'((TELQV_NS * 1000 + CLK_PS - 1) / CLK_PS + SYNC_STAGES + 2);
  // write-low time before the enable may rise; covers the pulse width
  localparam logic [7:0] WEND_CY = 8'(TWLQZ_CY + TDVWH_CY);

  // reset value of the enable, strobe and drive-enable pins
  localparam logic PIN_IDLE = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ASU  = 2'b01,
    ST_ACT  = 2'b10,
    ST_REC  = 2'b11
  } lar_state_t;

endpackage

`default_nettype wire

// [lar_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module lar_sync
  import lar_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // asynchronous level in, filtered level out
  input wire logic async_i,
  output logic level_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_nxt;

  // a change counts only once stages two and three agree
  always_comb
  begin
    level_nxt = level_o;
    if (s2_r == s3_r)
    begin
      level_nxt = s3_r;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_o <= 1'b0;
    end
    else
    begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_o <= level_nxt;
    end
  end

endmodule // lar_sync

`default_nettype wire

// [lar_ram_model.sv]
`timescale 1ns/100ps
`default_nettype none
module lar_ram_model
(
  // device pins
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic [9:0] addr,
  input wire logic d,
  output logic q
);
  logic mem [1024] = '{default: 1'b0};
  logic [9:0] a = 10'h000;
  logic vld = 1'b0;
  always @(negedge ce_n)
  begin
    a = addr;
    vld = 1'b0;
    #250 vld = 1'b1;
  end
  // first rise of the enable or the strobe ends the write
  always @(posedge ce_n or posedge we_n)
    if (!ce_n || !we_n)
      mem[a] = d;
  // off drives the inverse so a stale sample cannot pass
  assign q = (!ce_n && we_n && vld) ? mem[a] : !mem[a];
endmodule // lar_ram_model
`default_nettype wire

// [lar_ctrl_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module lar_ctrl_chk
  import lar_pkg::*;
#(
  parameter int ADDR_W = 10
)
(
  // watched pins
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ram_ce_n,
  input wire logic ram_we_n,
  input wire logic [ADDR_W-1:0] ram_addr,
  input wire logic ram_d,
  input wire logic ram_d_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // high count starts full: reset idles the enable
  int hi, wl, ds;
  always_ff @(posedge mclk)
  begin
    hi <= !rst_n ? 20 : ram_ce_n ? hi + 1 : 0;
    wl <= ram_we_n ? 0 : wl + 1;
    ds <= $stable(ram_d) ? ds + 1 : 0;
  end
  a_ce_high_min: assert property (
    $fell(ram_ce_n) |-> hi >= TEHEL_CY) else $error("enable high short");
  a_we_setup: assert property (
    $rose(ram_ce_n) && !ram_we_n |-> wl >= TWLWH_CY)
    else $error("strobe setup short");
  a_oe_after_we: assert property (
    $fell(ram_d_oe_n) |-> wl >= TWLQZ_CY) else $error("drive too early");
  a_data_setup: assert property (
    $rose(ram_ce_n) && !ram_we_n |-> ds >= TDVWH_CY ##1 $stable(ram_d))
    else $error("data not stable");
  a_we_rise_off: assert property (
    $rose(ram_we_n) |-> ram_ce_n) else $error("strobe rose in cycle");
  a_addr_hold: assert property (
    !ram_ce_n |-> $stable(ram_addr)) else $error("address moved");
endmodule // lar_ctrl_chk
bind lar_ctrl lar_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (.mclk(mclk),
  .rst_n(rst_n), .ram_ce_n(ram_ce_n), .ram_we_n(ram_we_n),
  .ram_addr(ram_addr), .ram_d(ram_d), .ram_d_oe_n(ram_d_oe_n));
`default_nettype wire

// [tb_lar_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_lar_ctrl;
  logic mclk = 0, rst_n = 0, cmd_valid = 0, cmd_write = 0, cmd_rmw = 0;
  logic cmd_burst = 0, cmd_wdata = 0, cmd_ready, rsp_valid, rsp_rdata;
  logic ram_ce_n, ram_we_n, ram_d, ram_d_oe_n, ram_q;
  logic [9:0] cmd_addr = 10'h000, ram_addr;
  int err_count = 0, cmp_count = 0;
  always #2.5 mclk = !mclk;
  lar_ctrl #(.ADDR_W(10)) dut (.mclk(mclk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_rmw(cmd_rmw), .cmd_burst(cmd_burst), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .ram_ce_n(ram_ce_n), .ram_we_n(ram_we_n), .ram_addr(ram_addr),
    .ram_d(ram_d), .ram_d_oe_n(ram_d_oe_n), .ram_q(ram_q));
  lar_ram_model u_ram (.ce_n(ram_ce_n), .we_n(ram_we_n), .addr(ram_addr),
    .d(ram_d), .q(ram_q));
  task automatic chk(logic g, logic e);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t got %b want %b", $time, g, e);
    end
  endtask
  // one command, waits for the answer; q is the returned bit
  task automatic op(logic w, logic m, logic b, logic [9:0] a, logic d,
    output logic q);
    int n;
    for (n = 0; n < 99 && cmd_ready !== 1'b1; n++) @(negedge mclk);
    chk(n < 99, 1'b1);
    {cmd_valid, cmd_write, cmd_rmw, cmd_burst} = {1'b1, w, m, b};
    {cmd_addr, cmd_wdata} = {a, d};
    @(negedge mclk);
    cmd_valid = 0;
    for (n = 0; n < 300 && rsp_valid !== 1'b1; n++) @(negedge mclk);
    chk(n < 300, 1'b1);
    // still recovering with the enable high, so no new command is taken
    chk(cmd_ready, 1'b0);
    q = rsp_rdata;
  endtask
  task automatic t_plain;
    logic q;
    for (int i = 0; i < 4; i++)
      op(1, 0, 0, 10'(i * 10'h155), ^i[1:0], q);
    for (int i = 0; i < 4; i++)
    begin
      op(0, 0, 0, 10'(i * 10'h155), 0, q);
      chk(q, ^i[1:0]);
    end
  endtask
  task automatic t_burst;
    logic q;
    for (int i = 1; i < 4; i++)
      op(1, 0, 1, 10'(i), i[0], q);
    for (int i = 1; i < 4; i++)
    begin
      op(0, 0, 0, 10'(i), 0, q);
      chk(q, i[0]);
    end
  endtask
  task automatic t_rmw;
    logic q;
    op(0, 1, 0, 10'h155, 0, q);
    chk(q, 1'b1);
    op(0, 1, 0, 10'h155, 1, q);
    chk(q, 1'b0);
    op(0, 0, 0, 10'h155, 0, q);
    chk(q, 1'b1);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge mclk);
    rst_n = 1;
    t_plain;
    t_burst;
    t_rmw;
    conclude;
  end
  initial
  begin
    #30000;
    err_count++;
    conclude;
  end
endmodule // tb_lar_ctrl
`default_nettype wire
